// file: rtl/tcp_pkg.sv
// Constants and register map of the 16-bit compare, pulse and PWM timer.
package tcp_pkg;
  localparam logic [3:0] ADR_CTRL1     = 4'h0;
  localparam logic [3:0] ADR_CTRL2     = 4'h1;
  localparam logic [3:0] ADR_STATUS    = 4'h2;
  localparam logic [3:0] ADR_CAP1_HI   = 4'h3;
  localparam logic [3:0] ADR_CAP1_LO   = 4'h4;
  localparam logic [3:0] ADR_CMP1_HI   = 4'h5;
  localparam logic [3:0] ADR_CMP1_LO   = 4'h6;
  localparam logic [3:0] ADR_CNT_HI    = 4'h7;
  localparam logic [3:0] ADR_CNT_LO    = 4'h8;
  localparam logic [3:0] ADR_CAP2_HI   = 4'h9;
  localparam logic [3:0] ADR_CAP2_LO   = 4'hA;
  localparam logic [3:0] ADR_CMP2_HI   = 4'hB;
  localparam logic [3:0] ADR_CMP2_LO   = 4'hC;
  localparam logic [3:0] ADR_LAST      = 4'hC;
  // Control one fields.
  localparam int C1_CAP_IE   = 7;
  localparam int C1_CMP_IE   = 6;
  localparam int C1_FORCE2   = 4;
  localparam int C1_FORCE1   = 3;
  localparam int C1_LVL2     = 2;
  localparam int C1_EDGE1    = 1;
  localparam int C1_LVL1     = 0;
  // Control two fields.
  localparam int C2_PIN1_EN  = 7;
  localparam int C2_PIN2_EN  = 6;
  localparam int C2_ONESHOT  = 5;
  localparam int C2_PWM      = 4;
  localparam int C2_CLK_HI   = 3;
  localparam int C2_CLK_LO   = 2;
  localparam int C2_EDGE2    = 1;
  localparam int C2_EXT_EDGE = 0;
  // Status fields.
  localparam int ST_CAP1     = 7;
  localparam int ST_CMP1     = 6;
  localparam int ST_CAP2     = 4;
  localparam int ST_CMP2     = 3;
  localparam logic [15:0] CMP_RESET    = 16'h8000;
  localparam logic [15:0] CNT_RESET    = 16'hFFFC;
  localparam logic [15:0] CNT_RELOAD   = 16'hFFFC;
  localparam logic [15:0] CAP_ONESHOT  = 16'hFFFD;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [1:0]  CLK_DIV2     = 2'b00;
  localparam logic [1:0]  CLK_DIV4     = 2'b01;
  localparam logic [1:0]  CLK_DIV8     = 2'b10;
  localparam logic [1:0]  CLK_EXT      = 2'b11;
  typedef enum logic [1:0] {MODE_CMP, MODE_ONESHOT, MODE_PWM} tcp_mode_e;
endpackage

// file: rtl/tcp_timer.sv
// Compare, one-pulse and PWM logic of a 16-bit free-running timer.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
module tcp_timer
  import tcp_pkg::*;
(
  input  wire logic        clk_i,        // System clock, 100 MHz
  input  wire logic        rst_i,        // Synchronous reset, active high
  input  wire logic        cyc_i,        // Wishbone cycle
  input  wire logic        stb_i,        // Wishbone strobe
  input  wire logic        we_i,         // Wishbone write enable
  input  wire logic [5:0]  adr_i,        // Wishbone byte address
  input  wire logic [3:0]  sel_i,        // Wishbone byte select
  input  wire logic [31:0] dat_i,        // Wishbone write data
  output logic      [31:0] dat_o,        // Wishbone read data
  output logic             ack_o,        // Wishbone acknowledge
  output logic             err_o,        // Wishbone error, unmapped
  input  wire logic        global_mask_i, // Processor interrupt mask
  input  wire logic        trigger_in_pin_i,     // Capture input one
  input  wire logic        second_capture_pin_i, // Capture input two
  input  wire logic        ext_clk_i,    // External timer clock
  output logic             waveform_out_pin_o,   // Output pin one
  output logic             waveform_out_en_o,    // Pin one owned
  output logic             compare2_out_pin_o,   // Output pin two
  output logic             compare2_out_en_o,    // Pin two owned
  output logic             timer_irq_o   // Timer interrupt request
);

  logic [7:0]  timer_control_one_reg;
  logic [7:0]  timer_control_two_reg;
  logic [15:0] counter_reg;
  logic [15:0] cmp1_reg, cmp2_reg;      // Software-visible values.
  logic [15:0] cmp1_act_reg, cmp2_act_reg; // Values in use.
  logic        cmp1_inh_reg, cmp2_inh_reg;
  logic [15:0] capture1_value_reg, capture2_value_reg;
  logic        cap1_inh_reg, cap2_inh_reg;
  logic        capture1_flag_reg, capture2_flag_reg;
  logic        compare1_match_flag_reg, compare2_match_flag_reg;
  logic [3:0]  arm_reg;  // Status read seen with flag set: c1,m1,c2,m2.
  logic [2:0]  presc_reg;
  logic        ext_d_reg;
  logic        trig_d_reg, cap2_d_reg;
  logic        m1_done_reg, m2_done_reg;
  logic        pin1_reg, pin2_reg;

  // Mode decode; PWM takes precedence when both are selected.
  tcp_mode_e mode;
  always_comb begin
    if (timer_control_two_reg[C2_PWM])
      mode = MODE_PWM;
    else if (timer_control_two_reg[C2_ONESHOT])
      mode = MODE_ONESHOT;
    else
      mode = MODE_CMP;
  end

  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  // Bus decode: one-cycle answer, ack low for the cycle after.
  logic        req;
  logic        hit;
  logic [3:0]  widx;
  assign req  = cyc_i && stb_i && !ack_o && !err_o;
  assign widx = adr_i[5:2];
  assign hit  = (widx <= ADR_LAST);
  logic wr, rd;
  logic [7:0] wb;
  assign wr = req && hit && we_i && sel_i[0];
  assign rd = req && hit && !we_i;
  assign wb = dat_i[7:0];

  // Timer tick: prescaled clock or external edge.
  logic [1:0] clk_sel;
  logic       tick;
  assign clk_sel = {timer_control_two_reg[C2_CLK_HI],
                    timer_control_two_reg[C2_CLK_LO]};
  always_comb begin
    case (clk_sel)
      CLK_DIV2: tick = presc_reg[0];
      CLK_DIV4: tick = &presc_reg[1:0];
      CLK_DIV8: tick = &presc_reg;
      CLK_EXT:  tick = edge_hit(ext_d_reg, ext_clk_i,
                                timer_control_two_reg[C2_EXT_EDGE]);
      default:  tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      presc_reg <= 3'h0;
    else
      presc_reg <= presc_reg + 3'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_d_reg  <= 1'b0;
      trig_d_reg <= 1'b0;
      cap2_d_reg <= 1'b0;
    end else begin
      ext_d_reg  <= ext_clk_i;
      trig_d_reg <= trigger_in_pin_i;
      cap2_d_reg <= second_capture_pin_i;
    end
  end

  // Matches hold for the whole interval of equality; each acts once.
  logic eq1, eq2, m1, m2, trig, cap2_ev;
  assign eq1 = !cmp1_inh_reg && (counter_reg == cmp1_act_reg);
  assign eq2 = !cmp2_inh_reg && (counter_reg == cmp2_act_reg);
  assign m1  = eq1 && !m1_done_reg;
  assign m2  = eq2 && !m2_done_reg;
  assign trig = (mode == MODE_ONESHOT) &&
                edge_hit(trig_d_reg, trigger_in_pin_i,
                         timer_control_one_reg[C1_EDGE1]);
  assign cap2_ev = edge_hit(cap2_d_reg, second_capture_pin_i,
                            timer_control_two_reg[C2_EDGE2]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m1_done_reg <= 1'b0;
      m2_done_reg <= 1'b0;
    end else begin
      m1_done_reg <= eq1;
      m2_done_reg <= eq2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      counter_reg <= CNT_RESET;
    else if (trig)
      counter_reg <= CNT_RELOAD;
    // The reload takes the place of the tick that would leave the period
    // value, so that value lasts one full tick like every other count.
    else if (mode == MODE_PWM && eq2 && tick)
      counter_reg <= CNT_RELOAD;
    else if (tick)
      counter_reg <= counter_reg + 16'h0001;
  end

  // Control registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_one_reg <= CTRL_RESET;
      timer_control_two_reg <= CTRL_RESET;
    end else begin
      if (wr && widx == ADR_CTRL1)
        timer_control_one_reg <= wb;
      if (wr && widx == ADR_CTRL2)
        timer_control_two_reg <= wb;
    end
  end

  // Compare registers; high write inhibits, low write re-enables.
  logic pwm_end;
  assign pwm_end = (mode == MODE_PWM) && eq2 && tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp1_reg     <= CMP_RESET;
      cmp2_reg     <= CMP_RESET;
      cmp1_inh_reg <= 1'b0;
      cmp2_inh_reg <= 1'b0;
    end else begin
      if (wr && widx == ADR_CMP1_HI) begin
        cmp1_reg[15:8] <= wb;
        cmp1_inh_reg   <= 1'b1;
      end
      if (wr && widx == ADR_CMP1_LO) begin
        cmp1_reg[7:0] <= wb;
        cmp1_inh_reg  <= 1'b0;
      end
      if (wr && widx == ADR_CMP2_HI) begin
        cmp2_reg[15:8] <= wb;
        cmp2_inh_reg   <= 1'b1;
      end
      if (wr && widx == ADR_CMP2_LO) begin
        cmp2_reg[7:0] <= wb;
        cmp2_inh_reg  <= 1'b0;
      end
    end
  end

  // Active values follow software at once except in PWM, where they
  // wait for the period end so the output never glitches.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp1_act_reg <= CMP_RESET;
      cmp2_act_reg <= CMP_RESET;
    end else if (mode != MODE_PWM || pwm_end) begin
      cmp1_act_reg <= cmp1_reg;
      cmp2_act_reg <= cmp2_reg;
    end
  end

  // Flag clearing: arm on status read, clear on low-byte access.
  logic st_rd;
  logic clr_c1, clr_m1, clr_c2, clr_m2;
  assign st_rd  = rd && widx == ADR_STATUS;
  assign clr_c1 = arm_reg[3] && req && hit && widx == ADR_CAP1_LO;
  assign clr_m1 = arm_reg[2] && req && hit && widx == ADR_CMP1_LO;
  assign clr_c2 = arm_reg[1] && req && hit && widx == ADR_CAP2_LO;
  assign clr_m2 = arm_reg[0] && req && hit && widx == ADR_CMP2_LO;

  always_ff @(posedge clk_i) begin
    if (rst_i)
      arm_reg <= 4'h0;
    else if (st_rd)
      arm_reg <= {capture1_flag_reg, compare1_match_flag_reg,
                  capture2_flag_reg, compare2_match_flag_reg};
    else
      arm_reg <= arm_reg & ~{clr_c1, clr_m1, clr_c2, clr_m2};
  end

  // Compare flags; a new set wins over a clear in the same cycle.
  logic set_m1, set_m2;
  assign set_m1 = m1 && mode == MODE_CMP;
  assign set_m2 = m2 && mode != MODE_PWM;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare1_match_flag_reg <= 1'b0;
      compare2_match_flag_reg <= 1'b0;
    end else begin
      if (set_m1)
        compare1_match_flag_reg <= 1'b1;
      else if (clr_m1)
        compare1_match_flag_reg <= 1'b0;
      if (set_m2)
        compare2_match_flag_reg <= 1'b1;
      else if (clr_m2)
        compare2_match_flag_reg <= 1'b0;
    end
  end

  // Captures; reading the high byte inhibits until the low byte is accessed.
  logic set_c1, set_c2;
  assign set_c1 = trig || (mode == MODE_PWM && m2);
  assign set_c2 = cap2_ev && !cap2_inh_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture1_value_reg <= 16'h0000;
      capture2_value_reg <= 16'h0000;
      cap1_inh_reg       <= 1'b0;
      cap2_inh_reg       <= 1'b0;
      capture1_flag_reg  <= 1'b0;
      capture2_flag_reg  <= 1'b0;
    end else begin
      if (rd && widx == ADR_CAP1_HI)
        cap1_inh_reg <= 1'b1;
      else if (req && hit && widx == ADR_CAP1_LO)
        cap1_inh_reg <= 1'b0;
      if (rd && widx == ADR_CAP2_HI)
        cap2_inh_reg <= 1'b1;
      else if (req && hit && widx == ADR_CAP2_LO)
        cap2_inh_reg <= 1'b0;
      if (trig && !cap1_inh_reg)
        capture1_value_reg <= CAP_ONESHOT;
      if (set_c2)
        capture2_value_reg <= counter_reg;
      if (set_c1)
        capture1_flag_reg <= 1'b1;
      else if (clr_c1)
        capture1_flag_reg <= 1'b0;
      if (set_c2)
        capture2_flag_reg <= 1'b1;
      else if (clr_c2)
        capture2_flag_reg <= 1'b0;
    end
  end

  // Output pin one.
  logic en1, en2;
  assign en1 = timer_control_two_reg[C2_PIN1_EN];
  assign en2 = timer_control_two_reg[C2_PIN2_EN];
  always_ff @(posedge clk_i) begin
    if (rst_i)
      pin1_reg <= 1'b0;
    else if (en1) begin
      case (mode)
        MODE_CMP: begin
          if (timer_control_one_reg[C1_FORCE1] || m1)
            pin1_reg <= timer_control_one_reg[C1_LVL1];
        end
        MODE_ONESHOT: begin
          if (trig)
            pin1_reg <= timer_control_one_reg[C1_LVL2];
          else if (m1)
            pin1_reg <= timer_control_one_reg[C1_LVL1];
        end
        MODE_PWM: begin
          if (m2)
            pin1_reg <= timer_control_one_reg[C1_LVL2];
          else if (m1)
            pin1_reg <= timer_control_one_reg[C1_LVL1];
        end
        default: pin1_reg <= pin1_reg;
      endcase
    end
  end

  // Output pin two only serves compare mode.
  always_ff @(posedge clk_i) begin
    if (rst_i)
      pin2_reg <= 1'b0;
    else if (en2 && mode == MODE_CMP) begin
      if (timer_control_one_reg[C1_FORCE2] || m2)
        pin2_reg <= timer_control_one_reg[C1_LVL2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_out_pin_o <= 1'b0;
      waveform_out_en_o  <= 1'b0;
      compare2_out_pin_o <= 1'b0;
      compare2_out_en_o  <= 1'b0;
    end else begin
      waveform_out_pin_o <= pin1_reg;
      waveform_out_en_o  <= en1;
      compare2_out_pin_o <= pin2_reg;
      compare2_out_en_o  <= en2 && mode == MODE_CMP;
    end
  end

  // Interrupt: pending flags gated by enables and the global mask.
  always_ff @(posedge clk_i) begin
    if (rst_i)
      timer_irq_o <= 1'b0;
    else
      timer_irq_o <= !global_mask_i &&
        ((timer_control_one_reg[C1_CMP_IE] &&
          (compare1_match_flag_reg || compare2_match_flag_reg)) ||
         (timer_control_one_reg[C1_CAP_IE] &&
          (capture1_flag_reg || capture2_flag_reg)));
  end

  // Read mux.
  logic [7:0] rdata;
  always_comb begin
    case (widx)
      ADR_CTRL1:   rdata = timer_control_one_reg;
      ADR_CTRL2:   rdata = timer_control_two_reg;
      ADR_STATUS:  rdata = {capture1_flag_reg, compare1_match_flag_reg,
                            1'b0, capture2_flag_reg,
                            compare2_match_flag_reg, 3'b000};
      ADR_CAP1_HI: rdata = capture1_value_reg[15:8];
      ADR_CAP1_LO: rdata = capture1_value_reg[7:0];
      ADR_CMP1_HI: rdata = cmp1_reg[15:8];
      ADR_CMP1_LO: rdata = cmp1_reg[7:0];
      ADR_CNT_HI:  rdata = counter_reg[15:8];
      ADR_CNT_LO:  rdata = counter_reg[7:0];
      ADR_CAP2_HI: rdata = capture2_value_reg[15:8];
      ADR_CAP2_LO: rdata = capture2_value_reg[7:0];
      ADR_CMP2_HI: rdata = cmp2_reg[15:8];
      ADR_CMP2_LO: rdata = cmp2_reg[7:0];
      default:     rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && hit;
      err_o <= req && !hit;
      dat_o <= (req && hit && !we_i) ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end

endmodule

// file: verification/tcp_pins.sv
// Far-side pin model: trigger source and external timer clock source.
`timescale 1ns/1ns
module tcp_pins (
  input  wire logic clk_i,  // System clock
  input  wire logic rst_i,  // Reset, active high
  input  wire logic fire_i, // Request one trigger pulse
  input  wire logic rise_i, // Active trigger edge is rising
  input  wire logic run_i,  // External clock runs
  output logic      trig_o, // Trigger pin
  output logic      ext_o   // External clock pin
);
  logic [2:0] div_reg;
  logic [1:0] pul_reg;
  // The clock stands low while stopped, and its edges are four clocks apart.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) div_reg <= 3'h0;
    else div_reg <= div_reg + 3'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) pul_reg <= 2'h0;
    else if (fire_i) pul_reg <= 2'h3;
    else if (pul_reg != 2'h0) pul_reg <= pul_reg - 2'h1;
  end
  // The trigger idles at the level opposite to its active edge.
  assign trig_o = rise_i ^ (pul_reg == 2'h0);
  assign ext_o = div_reg[2];
endmodule

// file: verification/tcp_timer_asserts.sv
// Port checker of the compare, one-pulse and PWM timer.
`timescale 1ns/1ns
module tcp_timer_asserts
  import tcp_pkg::*;
(
  input wire logic        clk_i,              // Clock
  input wire logic        rst_i,              // Reset
  input wire logic        cyc_i,              // Cycle
  input wire logic        stb_i,              // Strobe
  input wire logic        we_i,               // Write
  input wire logic [5:0]  adr_i,              // Address
  input wire logic [3:0]  sel_i,              // Lanes
  input wire logic [31:0] dat_i,              // Write data
  input wire logic        ack_o,              // Acknowledge
  input wire logic        err_o,              // Error
  input wire logic        global_mask_i,      // Mask
  input wire logic        waveform_out_pin_o, // Pin one
  input wire logic        waveform_out_en_o,  // Pin one owned
  input wire logic        compare2_out_en_o,  // Pin two owned
  input wire logic        timer_irq_o         // Interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] c1_reg;
  logic [7:0] c2_reg;
  logic       req;
  logic       wr;
  logic       cmpm;
  logic       lv1;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign wr = req && we_i && sel_i[0];
  assign cmpm = !c2_reg[C2_ONESHOT] && !c2_reg[C2_PWM];
  assign lv1 = c1_reg[C1_LVL1];
  // Shadows of both controls follow writes at the taking edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) c1_reg <= CTRL_RESET;
    else if (wr && adr_i[5:2] == ADR_CTRL1) c1_reg <= dat_i[7:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) c2_reg <= CTRL_RESET;
    else if (wr && adr_i[5:2] == ADR_CTRL2) c2_reg <= dat_i[7:0];
  end
  property p_rst;
    disable iff (1'b0)
    rst_i |=> !waveform_out_pin_o && !waveform_out_en_o && !timer_irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not low");
  property p_mask;
    global_mask_i [*2] |=> !timer_irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_ack;
    req && adr_i[5:2] <= ADR_LAST |=> ack_o && !err_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_err;
    req && adr_i[5:2] > ADR_LAST |=> err_o && !ack_o;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_en1;
    $stable(c2_reg) [*3] |-> waveform_out_en_o == c2_reg[C2_PIN1_EN];
  endproperty
  a_en1: assert property (p_en1) else $error("pin one owner");
  property p_en2;
    $stable(c2_reg) [*3] |-> compare2_out_en_o == (c2_reg[C2_PIN2_EN] && cmpm);
  endproperty
  a_en2: assert property (p_en2) else $error("pin two owner");
  property p_force;
    (cmpm && c2_reg[C2_PIN1_EN] && c1_reg[C1_FORCE1] && $stable(c1_reg)
      && $stable(c2_reg)) [*3] |-> waveform_out_pin_o == lv1;
  endproperty
  a_force: assert property (p_force) else $error("forced level");
  property p_const;
    (!cmpm && lv1 == c1_reg[C1_LVL2] && $stable(c1_reg)
      && $stable(c2_reg)) [*4]
      ##0 waveform_out_pin_o == lv1 |=> waveform_out_pin_o == lv1;
  endproperty
  a_const: assert property (p_const) else $error("level moved");
endmodule
bind tcp_timer tcp_timer_asserts i_chk (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
  .err_o, .global_mask_i, .waveform_out_pin_o, .waveform_out_en_o,
  .compare2_out_en_o, .timer_irq_o
);

// file: verification/tcp_timer_bench.sv
// Self-checking bench of the compare, one-pulse and PWM timer.
`timescale 1ns/1ns
module tcp_timer_bench
  import tcp_pkg::*;
;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, global_mask_i, ack_o, err_o;
  logic [5:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic trig, sec_pin, ext_clk, wave, wave_en, pin2, pin2_en, irq;
  logic fire, rise, run, last_err;
  logic [7:0] q;
  int err_count, check_count, seed, now, s, c, d, a, b, t, r1, f1, r2;
  int divs[4] = '{2, 4, 8, 8};
  logic [3:0] ri[6] = '{ADR_CTRL1, ADR_CTRL2, ADR_CMP1_HI, ADR_CMP1_LO,
                        ADR_CMP2_HI, ADR_CMP2_LO};
  logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
  tcp_timer i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .global_mask_i, .trigger_in_pin_i(trig),
    .second_capture_pin_i(sec_pin), .ext_clk_i(ext_clk),
    .waveform_out_pin_o(wave), .waveform_out_en_o(wave_en),
    .compare2_out_pin_o(pin2), .compare2_out_en_o(pin2_en),
    .timer_irq_o(irq));
  tcp_pins i_pins (.clk_i, .rst_i, .fire_i(fire), .rise_i(rise),
    .run_i(run), .trig_o(trig), .ext_o(ext_clk));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) now <= now + 1;
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A hung bus is cut short, since nothing after it can be trusted.
  task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] v);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h0, v};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      $display("[ERR] bus answer expected 1 seen 0");
      results();
    end
    q = dat_o[7:0];
    last_err = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] i, input logic [7:0] e,
                     input string nm);
    wb(1'b0, i, 8'h00);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask
  task automatic wait_pin(input logic v, input int lim, output int tm);
    int k;
    k = 0;
    while (wave !== v && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    chk("waveform pin", {31'h0, v}, {31'h0, wave});
    tm = now;
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  initial begin
    seed = 32'h0fb2;
    err_count = 0;
    check_count = 0;
    now = 0;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    {global_mask_i, sec_pin, fire, run} = '0;
    rise = 1'b1;
    rst_i = 1'b1;
    do_reset();
    for (s = 0; s < 6; s++) rdc(ri[s], rv[s], "reset value");
    wb(1'b0, 4'hD, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, last_err});
    wb(1'b1, ADR_CTRL1, 8'h41);
    wb(1'b1, ADR_CTRL2, 8'hC0);
    wb(1'b1, ADR_CMP1_LO, 8'h30);
    wb(1'b1, ADR_CMP1_HI, 8'h00);
    repeat (100) @(posedge clk_i);
    chk("inhibited pin", 32'h0, {31'h0, wave});
    rdc(ADR_STATUS, 8'h00, "inhibited status");
    wb(1'b1, ADR_CMP1_LO, 8'hC0);
    wait_pin(1'b1, 600, t);
    chk("irq on", 32'h1, {31'h0, irq});
    global_mask_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq});
    global_mask_i <= 1'b0;
    rdc(ADR_STATUS, 8'h40, "match status");
    rdc(ADR_CMP1_LO, 8'hC0, "compare low");
    rdc(ADR_STATUS, 8'h00, "cleared status");
    wb(1'b1, ADR_CTRL2, 8'h40);
    wb(1'b1, ADR_CTRL1, 8'h40);
    wb(1'b1, ADR_CMP1_HI, 8'h01);
    wb(1'b1, ADR_CMP1_LO, 8'h00);
    for (t = 0; t < 400 && irq !== 1'b1; t++) @(posedge clk_i);
    chk("irq without pin", 32'h1, {31'h0, irq});
    chk("pin one owner", 32'h0, {31'h0, wave_en});
    rdc(ADR_STATUS, 8'h40, "match status");
    wb(1'b1, ADR_CMP1_LO, 8'h00);
    rdc(ADR_STATUS, 8'h00, "write cleared");
    for (s = 0; s < 2; s++) begin
      wb(1'b1, ADR_CTRL2, 8'hC0);
      wb(1'b1, ADR_CTRL1, 8'h18 | {5'h0, s[0], 1'b0, s[0]});
      repeat (4) @(posedge clk_i);
      chk("forced pin", s, {31'h0, wave});
      chk("forced pin two", s, {31'h0, pin2});
    end
    rdc(ADR_STATUS, 8'h00, "forced status");
    for (s = 0; s < 4; s++) begin
      rise <= s[0];
      do_reset();
      c = 1 + ($random(seed) & 31);
      d = divs[s];
      wb(1'b1, ADR_CMP1_HI, 8'h00);
      wb(1'b1, ADR_CMP1_LO, c[7:0]);
      wb(1'b1, ADR_CTRL1, 8'h04 | {6'h0, s[0], 1'b0});
      wb(1'b1, ADR_CTRL2, 8'hE1 | {4'h0, s[1:0], 2'b00});
      run <= (s == 3);
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      wait_pin(1'b1, 100, r1);
      wait_pin(1'b0, 2000, f1);
      t = f1 - r1;
      a = (c + 3) * d;
      chk("pulse clocks", a, (t >= a && t <= a+d+2) ? a : t);
      rdc(ADR_STATUS, 8'h80, "pulse status");
      rdc(ADR_CAP1_HI, 8'hFF, "capture high");
      rdc(ADR_CAP1_LO, 8'hFD, "capture low");
      run <= 1'b0;
    end
    do_reset();
    a = 2 + ($random(seed) & 7);
    b = a + 4 + ($random(seed) & 15);
    // Compare one stays inhibited until PWM runs, so no flag is left over.
    wb(1'b1, ADR_CMP1_LO, a[7:0]);
    wb(1'b1, ADR_CMP1_HI, 8'h00);
    wb(1'b1, ADR_CMP2_HI, 8'h00);
    wb(1'b1, ADR_CMP2_LO, b[7:0]);
    wb(1'b1, ADR_CTRL1, 8'hDC);
    wb(1'b1, ADR_CTRL2, 8'hF0);
    wb(1'b1, ADR_CMP1_LO, a[7:0]);
    wait_pin(1'b1, 400, t);
    wait_pin(1'b0, 400, t);
    wait_pin(1'b1, 400, r1);
    wait_pin(1'b0, 400, f1);
    wait_pin(1'b1, 400, r2);
    chk("pwm high", (a + 5) * 2, f1 - r1);
    chk("pwm period", (b + 5) * 2, r2 - r1);
    wb(1'b1, ADR_CMP2_LO, b[7:0] + 8'h08);
    wait_pin(1'b0, 400, t);
    wait_pin(1'b1, 400, r1);
    chk("old period", (b + 5) * 2, r1 - r2);
    wait_pin(1'b0, 400, t);
    wait_pin(1'b1, 400, r2);
    chk("new period", (b + 13) * 2, r2 - r1);
    sec_pin <= 1'b1;
    repeat (2) @(posedge clk_i);
    sec_pin <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdc(ADR_STATUS, 8'h90, "pwm status");
    chk("pwm irq", 32'h1, {31'h0, irq});
    wb(1'b1, ADR_CTRL1, 8'h05);
    repeat (4 * b + 40) @(posedge clk_i);
    chk("steady pin", 32'h1, {31'h0, wave});
    repeat (b + 5) @(posedge clk_i);
    chk("steady pin", 32'h1, {31'h0, wave});
    results();
  end
endmodule
